// ---- core/pio_host.sv ----
// host-side io-transfer sequencer with an axi4-lite command port
`default_nettype none
// What this block does
// - host never sends address zero to a device; refused unless clear-all
// - host refuses addresses that would form 66xx instructions
// - select strobe low with phase high is the read phase; host samples then
module pio_host
	import pio_pkg::*;
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// axi4-lite slave
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// device pins
	output logic               address_load_strobe,
	output logic               device_select_n,
	output logic               transfer_phase,
	output logic               irq_grant,
	input  wire logic [11:0]   dx_i,
	output logic [11:0]        dx_o,
	output logic               dx_oe,
	input  wire logic          skip_irq_n,
	input  wire logic          io_control_a_n,
	input  wire logic          io_control_b_n
);
	import pio_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	pio_state_e   state_ff;
	logic [7:0]   cnt_ff;
	logic [11:0]  word_ff;
	logic [11:0]  acc_ff;
	logic [11:0]  rdata_ff;
	logic         grant_ff;
	logic         refused_ff;
	logic         skip_ff;
	logic         ctla_ff;
	logic         ctlb_ff;
	logic         bvalid_ff;
	logic [1:0]   bresp_ff;
	logic         rvalid_ff;
	logic [31:0]  rdata_bus_ff;
	logic [1:0]   rresp_ff;

	logic         wr_fire;
	logic         rd_fire;
	logic         cmd_go;
	logic         cmd_bad;
	logic [4:0]   cmd_addr;
	logic         cnt_done;
	logic [11:0]  nxt_word;
	logic [7:0]   nxt_cnt;

	// ----------------------------------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------------------------------
	// address and data are taken together so no write half is stranded
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign s_axi_wready  = s_axi_awready;
	assign wr_fire       = s_axi_awready;
	assign s_axi_arready = !rvalid_ff;
	assign rd_fire       = s_axi_arvalid && !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_bus_ff;
	assign s_axi_rresp   = rresp_ff;

	// command decode; clear-all is the only word allowed at address zero
	assign cmd_addr = s_axi_wdata[CMD_ADDR_LSB +: 5];
	assign cmd_go   = wr_fire && (s_axi_awaddr == OFS_CMD) && s_axi_wstrb[0];
	assign cmd_bad  = !s_axi_wdata[CMD_CAF_BIT]
		&& ((cmd_addr == ADDR_INTERNAL)
		|| (cmd_addr[4:2] == ADDR_PORT_HI)
		|| (state_ff != PIO_IDLE));
	assign nxt_word = s_axi_wdata[CMD_CAF_BIT] ? CAF_WORD
		: {IOT_OPCODE, cmd_addr, s_axi_wdata[CMD_CTRL_LSB +: 4]};
	assign cnt_done = (cnt_ff == 8'h00);

	// write response; unmapped or read-only offsets answer slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (s_axi_awaddr == OFS_CTRL || s_axi_awaddr == OFS_CMD
				|| s_axi_awaddr == OFS_ACC) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	// software-written registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc_ff   <= ACC_RST;
			grant_ff <= 1'b0;
		end
		else if (wr_fire)
		begin
			if (s_axi_awaddr == OFS_ACC && s_axi_wstrb[0])
				acc_ff[7:0] <= s_axi_wdata[7:0];
			if (s_axi_awaddr == OFS_ACC && s_axi_wstrb[1])
				acc_ff[11:8] <= s_axi_wdata[11:8];
			if (s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0])
				grant_ff <= s_axi_wdata[CTRL_GRANT_BIT];
		end
	end

	// refused flag: set on a bad command, cleared by the next good one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			refused_ff <= 1'b0;
		else if (cmd_go)
			refused_ff <= cmd_bad;
	end

	// read data path
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff    <= 1'b0;
			rdata_bus_ff <= 32'h0000_0000;
			rresp_ff     <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_CTRL:   rdata_bus_ff <= {31'h0, grant_ff};
				OFS_ACC:    rdata_bus_ff <= {20'h0, acc_ff};
				OFS_STATUS: rdata_bus_ff <= {27'h0, ctlb_ff, ctla_ff, skip_ff,
					refused_ff, (state_ff != PIO_IDLE)};
				OFS_RDATA:  rdata_bus_ff <= {20'h0, rdata_ff};
				default:
				begin
					rdata_bus_ff <= 32'h0000_0000;
					rresp_ff     <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// io-transfer sequencer
	// ----------------------------------------------------------------
	// one instruction: load address, read phase, then write phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= PIO_IDLE;
			cnt_ff   <= 8'h00;
			word_ff  <= 12'h000;
		end
		else if (state_ff == PIO_IDLE)
		begin
			if (cmd_go && !cmd_bad)
			begin
				word_ff  <= nxt_word;
				state_ff <= PIO_ASETUP;
				cnt_ff   <= 8'(ADDR_SETUP_CYC - 1);
			end
		end
		else if (!cnt_done)
			cnt_ff <= cnt_ff - 8'h01;
		else
		begin
			// phases run in enum order; the last one wraps back to idle
			state_ff <= state_ff.next();
			cnt_ff   <= nxt_cnt;
		end
	end

	// length of the phase that follows the current one
	always_comb
	begin
		unique case (state_ff)
			PIO_ASETUP: nxt_cnt = 8'(LOAD_PULSE_CYC - 1);
			PIO_LOAD:   nxt_cnt = 8'(ADDR_HOLD_CYC - 1);
			PIO_AHOLD:  nxt_cnt = 8'(READ_DELAY_CYC - 1);
			PIO_RD_LOW: nxt_cnt = 8'(DATA_HOLD_CYC - 1);
			PIO_RD_GAP: nxt_cnt = 8'(DATA_SETUP_CYC - 1);
			PIO_WSETUP: nxt_cnt = 8'(WRITE_PULSE_CYC - 1);
			PIO_WR_LOW: nxt_cnt = 8'(DATA_HOLD_CYC - 1);
			default:    nxt_cnt = 8'h00;
		endcase
	end

	// sample at the end of the read strobe, after the longest device delay
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_ff <= 12'h000;
			skip_ff  <= 1'b0;
			ctla_ff  <= 1'b1;
			ctlb_ff  <= 1'b1;
		end
		else if (state_ff == PIO_RD_LOW && cnt_done)
		begin
			rdata_ff <= dx_i | acc_ff;
			skip_ff  <= !skip_irq_n;
			ctla_ff  <= io_control_a_n;
			ctlb_ff  <= io_control_b_n;
		end
	end

	// pin drivers; bus is released through the whole read phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			address_load_strobe <= 1'b0;
			device_select_n     <= 1'b1;
			transfer_phase      <= 1'b1;
			dx_o                <= 12'h000;
			dx_oe               <= 1'b0;
		end
		else
		begin
			address_load_strobe <= (state_ff == PIO_LOAD);
			device_select_n     <= !(state_ff == PIO_RD_LOW
				|| state_ff == PIO_WR_LOW);
			transfer_phase      <= !(state_ff == PIO_WSETUP
				|| state_ff == PIO_WR_LOW || state_ff == PIO_WHOLD);
			dx_oe <= (state_ff == PIO_ASETUP || state_ff == PIO_LOAD
				|| state_ff == PIO_AHOLD || state_ff == PIO_WSETUP
				|| state_ff == PIO_WR_LOW || state_ff == PIO_WHOLD);
			dx_o  <= (state_ff == PIO_WSETUP || state_ff == PIO_WR_LOW
				|| state_ff == PIO_WHOLD) ? acc_ff : word_ff;
		end
	end

	// grant level straight from its control bit
	assign irq_grant = grant_ff;
endmodule : pio_host
`default_nettype wire

// ---- shared/pio_pkg.sv ----
// constants for the io-transfer host controller
`default_nettype none
package pio_pkg;
	// ----------------------------------------------------------------
	// register map (byte offsets, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_ACC    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_RDATA  = 8'h10;
	// field positions
	localparam int CTRL_GRANT_BIT = 0;
	localparam int CMD_ADDR_LSB   = 0;
	localparam int CMD_CTRL_LSB   = 5;
	localparam int CMD_CAF_BIT    = 9;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_REFUSED_BIT = 1;
	localparam int ST_SKIP_BIT    = 2;
	localparam int ST_CTLA_BIT    = 3;
	localparam int ST_CTLB_BIT    = 4;
	// reset value and response codes
	localparam logic [11:0] ACC_RST   = 12'h000;
	localparam logic [1:0]  RESP_OKAY = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	// ----------------------------------------------------------------
	// instruction word: top three bits octal 6, then address, control
	// ----------------------------------------------------------------
	localparam logic [2:0]  IOT_OPCODE   = 3'b110;
	localparam logic [4:0]  ADDR_INTERNAL = 5'h00;
	localparam logic [2:0]  ADDR_PORT_HI = 3'b110;   // address range that yields 66xx
	localparam logic [11:0] CAF_WORD     = 12'hc07;  // octal 6007
	// ----------------------------------------------------------------
	// timing, in ns as printed, then in cycles of aclk
	// ----------------------------------------------------------------
	localparam int CLK_NS         = 10;
	localparam int ADDR_SETUP_NS  = 40;
	localparam int LOAD_PULSE_NS  = 120;
	localparam int ADDR_HOLD_NS   = 50;
	localparam int DATA_SETUP_NS  = 65;
	localparam int DATA_HOLD_NS   = 50;
	localparam int READ_DELAY_NS  = 215;
	localparam int WRITE_PULSE_NS = 150;
	localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOAD_PULSE_CYC  = (LOAD_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ADDR_HOLD_CYC   = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int DATA_SETUP_CYC  = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int DATA_HOLD_CYC   = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_DELAY_CYC  = (READ_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	// sequencer states
	typedef enum logic [3:0] {
		PIO_IDLE, PIO_ASETUP, PIO_LOAD, PIO_AHOLD, PIO_RD_LOW, PIO_RD_GAP,
		PIO_WSETUP, PIO_WR_LOW, PIO_WHOLD
	} pio_state_e;
endpackage : pio_pkg
`default_nettype wire

// ---- tb/pio_dev_model.sv ----
// behavioural model of the addressed io interface device and its peripheral
`default_nettype none
module pio_dev_model #(
	parameter logic [4:0] SEL = 5'h0b
) (
	input  wire logic        address_load_strobe,
	input  wire logic        device_select_n,
	input  wire logic        transfer_phase,
	input  wire logic [11:0] dx_i,
	input  wire logic [3:0]  sense,
	input  wire logic [11:0] periph,
	output logic      [11:0] dx_d,
	output logic             dx_en,
	output logic             skip_en,
	output logic             ctla_en,
	output logic             flag_line_1,
	output logic             flag_line_3
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] ctrl_reg_a = '0, ctrl_reg_b = '0, vr = '0, wcap = '0;
	logic [8:0]  ir = '0;
	logic [3:0]  sf = '0, ps = '0;
	logic        io_transfer_instr = 0, caf = 0;
	int          lc = 0;
	wire [3:0] code = ir[3:0];
	wire [1:0] si = {code[3], code[0]};
	wire sel = io_transfer_instr && ir[8:4] == SEL;
	wire rd = sel && !device_select_n && transfer_phase;
	wire rdp = rd && code[2:0] == 3'b000;
	// latch address and control on each load pulse
	always @(posedge address_load_strobe)
	begin
		ir = dx_i[8:0];
		io_transfer_instr = dx_i[11:9] == 3'b110;
		caf = dx_i == 12'hc07;
		lc++;
	end
	// edge sensing only; level mode left out to keep the model short
	always @(sense)
	begin
		sf = sf | (sense & ~ps);
		ps = sense;
	end
	// read phase end clears flags and sets or clears flops; write phase end loads registers
	always @(posedge device_select_n)
	begin
		if (transfer_phase && caf) sf = '0;
		if (transfer_phase && sel && code[2:1] == 2'b01) sf[si] = 1'b0;
		if (transfer_phase && sel && code[2:0] == 3'b110) ctrl_reg_a[8 + 2 * code[3]] = 1'b1;
		if (transfer_phase && sel && code[2:0] == 3'b111) ctrl_reg_a[8 + 2 * code[3]] = 1'b0;
		if (!transfer_phase && sel)
			case (code)
				4'b0101: ctrl_reg_a = dx_i & 12'hfaf;
				4'b1101: ctrl_reg_b = dx_i & 12'hff0;
				4'b1100: vr = dx_i & 12'hffc;
				4'b0001, 4'b1001: wcap = dx_i;
				default: ;
			endcase
	end
	assign flag_line_1 = ctrl_reg_a[8];
	assign flag_line_3 = ctrl_reg_a[10];
	assign dx_en = rdp || (rd && code == 4'b0100);
	assign dx_d = rdp ? periph : ctrl_reg_a;
	assign skip_en = rd && code[2:1] == 2'b01 && sf[si];
	assign ctla_en = dx_en;
endmodule : pio_dev_model
`default_nettype wire

// ---- tb/pio_host_bench.sv ----
// self-checking bench for the io-transfer host controller
`default_nettype none
module pio_host_bench;
	import pio_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] DEV = 5'h0b;
	localparam logic [3:0] PUL_C [4] = '{4'h0, 4'h8, 4'h1, 4'h9};
	localparam logic [3:0] FLG_C [4] = '{4'h6, 4'he, 4'h7, 4'hf};
	localparam logic [1:0] FLG_E [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
	localparam logic [3:0] SKP_C [4] = '{4'h2, 4'h3, 4'ha, 4'hb};
	localparam logic [3:0] REG_C [3] = '{4'h5, 4'hd, 4'hc};
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, address_load_strobe, device_select_n, transfer_phase;
	logic irq_grant, dx_oe, dx_en, skip_en, ctla_en, flag_line_1, flag_line_3, skip_irq_n;
	logic io_control_a_n, io_control_b_n;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat, rdv, st;
	logic [3:0]  s_axi_wstrb = 4'hf, sense = '0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [11:0] dx_i, dx_o, dx_d, periph = '0, cnt = '0, acc, keep;
	int          mismatches = 0, samples_checked = 0, n;
	pio_host i_pio_host (.*);
	pio_dev_model i_pio_dev_model (.*);
	// open-drain lines pulled up; a floating bus shows a changing pattern
	assign skip_irq_n = !skip_en;
	assign io_control_a_n = !ctla_en;
	assign io_control_b_n = 1'b1;
	assign dx_i = dx_oe ? dx_o : dx_en ? dx_d : cnt;
	always @(posedge aclk) cnt <= cnt + 12'h001;
	// free-running clock
	initial forever #5 aclk = ~aclk;
	function automatic logic [11:0] reg_exp(input logic [3:0] c, input logic [11:0] d);
		return c == 4'h5 ? d & 12'hfaf : c == 4'hd ? d & 12'hff0 : d & 12'hffc;
	endfunction : reg_exp
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// one instruction: command, wait for idle, collect status and read data
	task automatic run(input logic [4:0] a, input logic [3:0] c, input logic caf);
		wr(OFS_CMD, {22'h0, caf, c, a});
		do rd(OFS_STATUS); while (rdat[ST_BUSY_BIT] === 1'b1);
		st = rdat;
		rd(OFS_RDATA);
		rdv = rdat;
	endtask : run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// watchdog well beyond the expected run
	initial
	begin
		#400000;
		mismatches++;
		finish_test();
	end
	// main sequence
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(40562));
		rd(OFS_ACC);
		chk(rdat, {20'h0, ACC_RST});
		rd(8'h14);
		chk(rsp, RESP_SLVERR);
		wr(OFS_CTRL, 32'h1);
		chk(irq_grant, 1'b1);
		rd(OFS_CTRL);
		chk(rdat, 32'h1);
		wr(OFS_CTRL, 32'h0);
		chk(rsp, RESP_OKAY);
		chk(irq_grant, 1'b0);
		wr(OFS_STATUS, 32'h0);
		chk(rsp, RESP_SLVERR);
		$display("test bus done");
		foreach (REG_C[i])
		begin
			acc = 12'($urandom);
			wr(OFS_ACC, {20'h0, acc});
			run(DEV, REG_C[i], 1'b0);
			chk(REG_C[i] == 4'h5 ? i_pio_dev_model.ctrl_reg_a : REG_C[i] == 4'hd ?
				i_pio_dev_model.ctrl_reg_b : i_pio_dev_model.vr, reg_exp(REG_C[i], acc));
			if (i == 0) keep = reg_exp(4'h5, acc);
		end
		run(DEV ^ 5'h01, 4'h5, 1'b0);
		chk(i_pio_dev_model.ctrl_reg_a, keep);
		wr(OFS_ACC, 32'h0);
		run(DEV, 4'h4, 1'b0);
		chk(rdv, {20'h0, keep});
		chk(st[4:3], 2'b10);
		$display("test registers done");
		foreach (PUL_C[i])
		begin
			acc = 12'($urandom);
			periph <= 12'($urandom);
			wr(OFS_ACC, {20'h0, acc});
			run(DEV, PUL_C[i], 1'b0);
			chk(st[4:3], PUL_C[i][0] ? 2'b11 : 2'b10);
			chk(PUL_C[i][0] ? i_pio_dev_model.wcap : rdv, PUL_C[i][0] ? acc : periph | acc);
		end
		$display("test strobes done");
		wr(OFS_ACC, 32'h0);
		run(DEV, 4'h5, 1'b0);
		foreach (FLG_C[i])
		begin
			run(DEV, FLG_C[i], 1'b0);
			chk({flag_line_3, flag_line_1}, FLG_E[i]);
		end
		foreach (SKP_C[i])
		begin
			sense <= 4'b0001 << i;
			run(DEV, SKP_C[i], 1'b0);
			chk(st[ST_SKIP_BIT], 1'b1);
			sense <= 4'h0;
			run(DEV, SKP_C[i], 1'b0);
			chk(st[ST_SKIP_BIT], 1'b0);
		end
		run(DEV, 4'h6, 1'b0);
		sense <= 4'hf;
		run(5'h00, 4'h0, 1'b1);
		chk(i_pio_dev_model.sf, 4'h0);
		chk({flag_line_3, flag_line_1}, 2'b01);
		$display("test flags and sense done");
		n = i_pio_dev_model.lc;
		run(5'h00, 4'h5, 1'b0);
		chk(st[ST_REFUSED_BIT], 1'b1);
		run({3'b110, 2'($urandom)}, 4'h5, 1'b0);
		chk(st[ST_REFUSED_BIT], 1'b1);
		chk(i_pio_dev_model.lc, n);
		run(DEV, 4'h7, 1'b0);
		chk(st[ST_REFUSED_BIT], 1'b0);
		chk(i_pio_dev_model.lc, n + 1);
		$display("test refusals done");
		finish_test();
	end
endmodule : pio_host_bench
`default_nettype wire

// ---- tb/pio_host_checker.sv ----
// assertions on the pins and bus port of the io-transfer host
`default_nettype none
module pio_host_checker
	import pio_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        address_load_strobe,
	input wire logic        device_select_n,
	input wire logic        transfer_phase,
	input wire logic [11:0] dx_o,
	input wire logic        dx_oe,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// loaded words carry the opcode; address zero goes out only in clear-all, 66xx addresses never
	a_load_opcode: assert property (address_load_strobe |-> dx_oe && dx_o[11:9] == 3'b110)
		else $error("load without transfer opcode");
	a_addr_nonzero: assert property (
		address_load_strobe && dx_o != CAF_WORD |-> dx_o[8:4] != ADDR_INTERNAL)
		else $error("address zero sent");
	a_port_range: assert property (address_load_strobe |-> dx_o[8:6] != ADDR_PORT_HI)
		else $error("reserved port range sent");
	// load pulse long enough for the device to latch
	a_load_width: assert property ($rose(address_load_strobe) |-> address_load_strobe[*8])
		else $error("load pulse too short");
	// bus released in read phase, driven in write phase
	a_read_release: assert property (!device_select_n && transfer_phase |-> !dx_oe)
		else $error("bus driven in read phase");
	a_write_drive: assert property (!device_select_n && !transfer_phase |-> dx_oe)
		else $error("bus idle in write phase");
	a_read_gap: assert property ($rose(device_select_n) && transfer_phase |-> device_select_n[*5])
		else $error("write phase starts too soon");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	c_read: cover property ($fell(device_select_n) && transfer_phase);
	c_write: cover property ($fell(device_select_n) && !transfer_phase);
	c_clear: cover property (address_load_strobe && dx_o == CAF_WORD);
endmodule : pio_host_checker
bind pio_host pio_host_checker i_pio_host_checker (.*);
`default_nettype wire
